// >>> inc/sdh_regs.svh
// Purpose: constants for the greater-or-equal data search command
// Assumes: ten-byte command block, bytes numbered from 0
// Notes: status and sense codes as sent on the bus
`ifndef SDH_REGS_SVH
`define SDH_REGS_SVH

// command block fields
`define SDH_OPCODE 8'h30
`define SDH_LUN_MSB 7
`define SDH_LUN_LSB 5
`define SDH_NEG_BIT 4
`define SDH_LAYOUT_MSB 3
`define SDH_LAYOUT_LSB 2
`define SDH_SPAN_BIT 1
`define SDH_REL_BIT 0
`define SDH_RETRY_BIT 7
`define SDH_FLAG_BIT 1
`define SDH_LINK_BIT 0

// status codes
`define SDH_ST_GOOD 8'h00
`define SDH_ST_CHECK 8'h02
`define SDH_ST_COND_MET 8'h04
`define SDH_ST_INTER_MET 8'h14

// sense keys
`define SDH_KEY_NO_SENSE 4'h0
`define SDH_KEY_ILLEGAL 4'h5
`define SDH_KEY_EQUAL 4'hc

// sizes
`define SDH_BLOCK_BYTES 512
`define SDH_PAT_BYTES 4
`define SDH_NUM_FIELDS 2
`define SDH_MAX_BLOCKS 256

`endif

// >>> inc/sdh_pkg.sv
// Purpose: types for the data search command
// Assumes: sdh_regs.svh supplies the sizes
// Notes: pattern bytes are left aligned, first byte in the top lane
`include "sdh_regs.svh"
package sdh_pkg;

  typedef struct packed {
    logic ok;
    logic [2:0] lun;
    logic negated_match_flag;
    logic [1:0] layout;
    logic spanned_records_flag;
    logic relative_block_addressing;
    logic [31:0] lba;
    logic [15:0] blocks;
    logic error_retry_bit;
    logic flag;
    logic link;
  } sdh_cmd_type;

  typedef struct packed {
    logic [31:0] rec_size;
    logic [31:0] first_off;
    logic [31:0] rec_count;
  } sdh_param_type;

  typedef struct packed {
    logic [31:0] disp;
    logic [15:0] size;
    logic [`SDH_PAT_BYTES*8-1:0] pattern;
  } sdh_field_type;

  typedef struct packed {
    logic [3:0] key;
    logic valid_address_indicator;
    logic [31:0] info;
    logic [31:0] rec_off;
  } sdh_sense_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PARAM = 5'h02,
    ST_REQ = 5'h04,
    ST_DATA = 5'h08,
    ST_END = 5'h10
  } sdh_state_type;

endpackage

// >>> rtl/sdh_cdb_decode.sv
// Purpose: splits the ten command block bytes into fields
// Assumes: byte 0 at bits 79:72
// Notes: purely combinational
`timescale 1ns/1ps
`include "sdh_regs.svh"
module sdh_cdb_decode
  import sdh_pkg::*;
(
  // command block
  input wire logic [79:0] i_cdb,
  // decoded fields
  output sdh_cmd_type o_cmd
);
  function automatic logic [7:0] cdb_byte(input logic [79:0] c, input int n);
    cdb_byte = c[79-8*n -: 8];
  endfunction

  logic [7:0] b1;
  logic [7:0] b9;

  always_comb
  begin
    b1 = cdb_byte(i_cdb, 1);
    b9 = cdb_byte(i_cdb, 9);
    o_cmd.ok = (cdb_byte(i_cdb, 0) == `SDH_OPCODE); // see (R1)
    // see (R4) (R27)
    o_cmd.lun = b1[`SDH_LUN_MSB:`SDH_LUN_LSB];
    o_cmd.negated_match_flag = b1[`SDH_NEG_BIT]; // see (R15)
    o_cmd.layout = b1[`SDH_LAYOUT_MSB:`SDH_LAYOUT_LSB];
    o_cmd.spanned_records_flag = b1[`SDH_SPAN_BIT];
    o_cmd.relative_block_addressing = b1[`SDH_REL_BIT];
    o_cmd.lba = {cdb_byte(i_cdb, 2), cdb_byte(i_cdb, 3), cdb_byte(i_cdb, 4),
                 cdb_byte(i_cdb, 5)};
    o_cmd.blocks = {cdb_byte(i_cdb, 7), cdb_byte(i_cdb, 8)}; // see (R6)
    o_cmd.error_retry_bit = b9[`SDH_RETRY_BIT];
    o_cmd.flag = b9[`SDH_FLAG_BIT];
    o_cmd.link = b9[`SDH_LINK_BIT];
  end
endmodule

// >>> rtl/sdh_field_cmp.sv
// Purpose: compares one argument field against record bytes
// Assumes: bytes of a record arrive in order, most significant first
// Notes: pattern bytes past PAT_BYTES compare against zero
`timescale 1ns/1ps
module sdh_field_cmp
  import sdh_pkg::*;
#(
  parameter int PAT_BYTES = 4
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // record byte stream
  input wire logic i_start,
  input wire logic i_en,
  input wire logic [31:0] i_pos,
  input wire logic [7:0] i_byte,
  input sdh_field_type i_field,
  // result including the current byte
  output logic o_ge,
  output logic o_eq
);
  logic lt;
  logic gt;
  logic next_lt;
  logic next_gt;
  logic [31:0] k;
  logic [7:0] pbyte;

  always_comb
  begin
    next_lt = i_start ? 1'b0 : lt;
    next_gt = i_start ? 1'b0 : gt;
    k = i_pos - i_field.disp; // see (R26)
    pbyte = 8'h00;
    if (k < PAT_BYTES)
    begin
      pbyte = i_field.pattern[PAT_BYTES*8-1-8*k[7:0] -: 8];
    end
    if (i_en && i_pos >= i_field.disp && k < {16'h0000, i_field.size} && !next_lt && !next_gt)
    begin
      next_gt = i_byte > pbyte;
      next_lt = i_byte < pbyte;
    end
    o_ge = !next_lt; // see (R2)
    o_eq = !next_lt && !next_gt;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lt <= 1'b0;
      gt <= 1'b0;
    end
    else if (i_en)
    begin
      lt <= next_lt;
      gt <= next_gt;
    end
  end
endmodule

// >>> rtl/sdh_search_top.sv
// Purpose: executes the greater-or-equal data search command
// Assumes: disk bytes stream per block after a block read pulse
// Notes: status and sense are registered, one result per command
//
// Contract
// (R1) opcode 30h selects this search
// (R2) match when record data >= argument
// (R3) parameter list follows the command block
// (R4) byte 1 holds unit, flags, layout
// (R5) initiator sends address MSB first, byte6 zero
// (R6) block count from bytes 7 and 8
// (R7) may disconnect during search if enabled
// (R8) linked success fetches next, relative to match
// (R9) linked miss breaks chain, ending status
// (R10) unlinked success ends with condition met
// (R11) sense key equal on exact, else none
// (R12) valid address set, info holds match block
// (R13) record offset in first additional sense bytes
// (R14) miss gives no sense, valid cleared
// (R15) negated match flag is reported
// (R16) layout 0 fixed, else length prefix
// (R17) spanned records may cross blocks
// (R18) skip leftover space smaller than record
// (R19) relative address adds signed offset
// (R20) relative without prior access is illegal
// (R21) flag with link requests interrupt
// (R22) link chains next, status per command
// (R23) stop on record or block count exhausted
// (R24) first offset only in first block
// (R25) all fields must match in one record
// (R26) field displacement from record start
// (R27) relative addressing from byte 1 bit 0
`timescale 1ns/1ps
`include "sdh_regs.svh"
module sdh_search_top
  import sdh_pkg::*;
#(
  parameter int BLOCK_BYTES = `SDH_BLOCK_BYTES,
  parameter int PAT_BYTES = `SDH_PAT_BYTES,
  parameter int NUM_FIELDS = `SDH_NUM_FIELDS
)
(
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // command block and parameter list
  input wire logic I_CDB_VALID,
  input wire logic [79:0] I_CDB,
  input wire logic I_PARAM_VALID,
  input sdh_param_type I_PARAM,
  input sdh_field_type [NUM_FIELDS-1:0] I_FIELDS,
  input wire logic I_DISC_ENABLE,
  // disk data
  input wire logic I_DISK_VALID,
  input wire logic [7:0] I_DISK_BYTE,
  output logic O_DISK_READY,
  output logic O_BLK_RD,
  output logic [31:0] O_BLK_LBA,
  // status and sense
  output logic O_BUSY,
  output logic O_DISCONNECT,
  output logic O_STATUS_VALID,
  output logic [7:0] O_STATUS,
  output logic O_FETCH_NEXT,
  output logic O_LINK_IRQ,
  output logic O_NEGATED_MATCH,
  output sdh_sense_type O_SENSE
);
  // pattern lanes are fixed by the field struct
  if (BLOCK_BYTES < 1 || BLOCK_BYTES > 65536 || PAT_BYTES != `SDH_PAT_BYTES ||
      NUM_FIELDS < 1)
  begin : gen_bad_params
    $error("sdh_search_top: unsupported parameters");
  end

  function automatic logic [31:0] prefix_len(input logic [1:0] layout);
    case (layout)
      2'h1: prefix_len = 32'h1;
      2'h2: prefix_len = 32'h2;
      default: prefix_len = 32'h4;
    endcase
  endfunction

  localparam logic [31:0] BLK = 32'(BLOCK_BYTES);

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  sdh_cmd_type dec;
  sdh_cdb_decode u_dec (
    .i_cdb(I_CDB),
    .o_cmd(dec)
  );

  sdh_state_type state, next_state;
  sdh_cmd_type cmd, next_cmd;
  sdh_param_type prm, next_prm;
  sdh_field_type [NUM_FIELDS-1:0] fld, next_fld;
  sdh_sense_type sense, next_sense;
  logic [31:0] lba, next_lba;
  logic [31:0] blk_pos, next_blk_pos;
  logic [31:0] rec_pos, next_rec_pos;
  logic [31:0] rec_len, next_rec_len;
  logic [31:0] rec_left, next_rec_left;
  logic [15:0] blk_left, next_blk_left;
  logic [31:0] rec_lba, next_rec_lba;
  logic [31:0] rec_off, next_rec_off;
  logic first, next_first;
  logic skip, next_skip;
  logic found, next_found;
  logic exact, next_exact;
  logic err, next_err;
  logic chain, next_chain;
  logic last_valid, next_last_valid;
  logic [2:0] last_lun, next_last_lun;
  logic [31:0] last_lba, next_last_lba;
  logic status_valid, next_status_valid;
  logic [7:0] status, next_status;
  logic fetch, next_fetch;
  logic irq, next_irq;

  logic take;
  logic rec_start;
  logic cmp_en;
  logic [31:0] acc_len;
  logic rec_end;
  logic [NUM_FIELDS-1:0] ge;
  logic [NUM_FIELDS-1:0] eq;

  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++)
    begin : gen_cmp
      sdh_field_cmp #(.PAT_BYTES(PAT_BYTES)) u_cmp (
        .i_clk(I_SYS_CLK),
        .i_rst_n(rst_n),
        .i_start(rec_start),
        .i_en(cmp_en),
        .i_pos(rec_pos),
        .i_byte(I_DISK_BYTE),
        .i_field(fld[g]),
        .o_ge(ge[g]),
        .o_eq(eq[g])
      );
    end
  endgenerate

  // byte classification
  always_comb
  begin
    take = (state == ST_DATA) && I_DISK_VALID;
    rec_start = 1'b0;
    cmp_en = 1'b0;
    if (take && !skip && !(first && blk_pos < prm.first_off)) // see (R24)
    begin
      rec_start = (rec_pos == 32'h0);
      // see (R17) (R18)
      cmp_en = !(rec_start && !cmd.spanned_records_flag && (BLK - blk_pos) < prm.rec_size);
    end
    // see (R16)
    acc_len = (rec_pos < prefix_len(cmd.layout)) ? {rec_len[23:0], I_DISK_BYTE} : rec_len;
    if (cmd.layout == 2'h0)
    begin
      rec_end = (rec_pos + 32'h1) >= prm.rec_size;
    end
    else
    begin
      rec_end = (rec_pos + 32'h1) >= prefix_len(cmd.layout) && (rec_pos + 32'h1) >= acc_len;
    end
  end

  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_prm = prm;
    next_fld = fld;
    next_sense = sense;
    next_lba = lba;
    next_blk_pos = blk_pos;
    next_rec_pos = rec_pos;
    next_rec_len = rec_len;
    next_rec_left = rec_left;
    next_blk_left = blk_left;
    next_rec_lba = rec_lba;
    next_rec_off = rec_off;
    next_first = first;
    next_skip = skip;
    next_found = found;
    next_exact = exact;
    next_err = err;
    next_chain = chain;
    next_last_valid = last_valid;
    next_last_lun = last_lun;
    next_last_lba = last_lba;
    next_status_valid = 1'b0;
    next_status = status;
    next_fetch = 1'b0;
    next_irq = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (I_CDB_VALID)
        begin
          next_cmd = dec;
          next_found = 1'b0;
          next_exact = 1'b0;
          next_err = 1'b0;
          next_state = ST_PARAM;
          if (!dec.ok) // see (R1)
          begin
            next_err = 1'b1;
            next_state = ST_END;
          end
          else if (dec.relative_block_addressing)
          begin
            // see (R20)
            if (!(chain && last_valid && last_lun == dec.lun))
            begin
              next_err = 1'b1;
              next_state = ST_END;
            end
            next_lba = last_lba + dec.lba; // see (R19) (R8)
          end
          else
          begin
            next_lba = dec.lba;
          end
          next_blk_left = dec.blocks; // see (R6)
        end
      end
      ST_PARAM:
      begin
        if (I_PARAM_VALID) // see (R3)
        begin
          next_prm = I_PARAM;
          next_fld = I_FIELDS;
          next_rec_left = I_PARAM.rec_count;
          next_first = 1'b1;
          next_skip = 1'b0;
          next_blk_pos = 32'h0;
          next_rec_pos = 32'h0;
          next_rec_len = 32'h0;
          // see (R6) (R23)
          next_state = (blk_left == 16'h0 || I_PARAM.rec_count == 32'h0) ? ST_END : ST_REQ;
        end
      end
      ST_REQ:
      begin
        next_state = ST_DATA;
      end
      ST_DATA:
      begin
        if (take)
        begin
          if (rec_start && !cmp_en)
          begin
            next_skip = 1'b1; // see (R18)
          end
          if (cmp_en)
          begin
            if (rec_start)
            begin
              next_rec_lba = lba;
              next_rec_off = blk_pos;
            end
            next_rec_len = acc_len;
            next_rec_pos = rec_pos + 32'h1;
            if (rec_end)
            begin
              next_rec_pos = 32'h0;
              next_rec_len = 32'h0;
              if (&ge) // see (R25) (R2)
              begin
                next_found = 1'b1;
                next_exact = &eq;
                next_state = ST_END;
              end
              else
              begin
                next_rec_left = rec_left - 32'h1;
                if (rec_left == 32'h1)
                begin
                  next_state = ST_END; // see (R23)
                end
              end
            end
          end
          next_blk_pos = blk_pos + 32'h1;
          if (blk_pos == BLK - 32'h1)
          begin
            next_blk_pos = 32'h0;
            next_lba = lba + 32'h1;
            next_first = 1'b0; // see (R24)
            next_skip = 1'b0;
            next_blk_left = blk_left - 16'h1;
            if (!cmd.spanned_records_flag) // see (R17)
            begin
              next_rec_pos = 32'h0;
              next_rec_len = 32'h0;
            end
            if (next_state == ST_DATA)
            begin
              next_state = (blk_left == 16'h1) ? ST_END : ST_REQ; // see (R23)
            end
          end
        end
      end
      ST_END:
      begin
        next_status_valid = 1'b1;
        next_state = ST_IDLE;
        if (err)
        begin
          next_status = `SDH_ST_CHECK; // see (R20)
          next_sense = '0;
          next_sense.key = `SDH_KEY_ILLEGAL;
          next_chain = 1'b0;
          next_last_valid = 1'b0;
        end
        else if (found)
        begin
          // see (R11) (R12) (R13)
          next_sense.key = exact ? `SDH_KEY_EQUAL : `SDH_KEY_NO_SENSE;
          next_sense.valid_address_indicator = 1'b1;
          next_sense.info = rec_lba;
          next_sense.rec_off = rec_off;
          next_last_valid = 1'b1;
          next_last_lun = cmd.lun;
          next_last_lba = rec_lba; // see (R8)
          if (cmd.link) // see (R8) (R22)
          begin
            next_status = `SDH_ST_INTER_MET;
            next_fetch = 1'b1;
            next_irq = cmd.flag; // see (R21)
            next_chain = 1'b1;
          end
          else
          begin
            next_status = `SDH_ST_COND_MET; // see (R10)
            next_chain = 1'b0;
          end
        end
        else
        begin
          next_sense = '0; // see (R14)
          next_sense.key = `SDH_KEY_NO_SENSE;
          next_status = `SDH_ST_GOOD; // see (R9)
          next_chain = 1'b0;
          next_last_valid = 1'b0;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cmd <= '0;
      prm <= '0;
      fld <= '0;
      sense <= '0;
      lba <= 32'h0;
      blk_pos <= 32'h0;
      rec_pos <= 32'h0;
      rec_len <= 32'h0;
      rec_left <= 32'h0;
      blk_left <= 16'h0;
      rec_lba <= 32'h0;
      rec_off <= 32'h0;
      first <= 1'b0;
      skip <= 1'b0;
      found <= 1'b0;
      exact <= 1'b0;
      err <= 1'b0;
      chain <= 1'b0;
      last_valid <= 1'b0;
      last_lun <= 3'h0;
      last_lba <= 32'h0;
      status_valid <= 1'b0;
      status <= 8'h00;
      fetch <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      prm <= next_prm;
      fld <= next_fld;
      sense <= next_sense;
      lba <= next_lba;
      blk_pos <= next_blk_pos;
      rec_pos <= next_rec_pos;
      rec_len <= next_rec_len;
      rec_left <= next_rec_left;
      blk_left <= next_blk_left;
      rec_lba <= next_rec_lba;
      rec_off <= next_rec_off;
      first <= next_first;
      skip <= next_skip;
      found <= next_found;
      exact <= next_exact;
      err <= next_err;
      chain <= next_chain;
      last_valid <= next_last_valid;
      last_lun <= next_last_lun;
      last_lba <= next_last_lba;
      status_valid <= next_status_valid;
      status <= next_status;
      fetch <= next_fetch;
      irq <= next_irq;
    end
  end

  // outputs
  assign O_DISK_READY = (state == ST_DATA);
  assign O_BLK_RD = (state == ST_REQ);
  assign O_BLK_LBA = lba;
  assign O_BUSY = (state != ST_IDLE);
  assign O_DISCONNECT = I_DISC_ENABLE && (state == ST_REQ || state == ST_DATA); // see (R7)
  assign O_STATUS_VALID = status_valid;
  assign O_STATUS = status;
  assign O_FETCH_NEXT = fetch;
  assign O_LINK_IRQ = irq;
  assign O_NEGATED_MATCH = cmd.negated_match_flag; // see (R15)
  assign O_SENSE = sense;
endmodule

// >>> tb/sdh_search_checker.sv
// Purpose: port checks for the data search command
// Assumes: one clock, reset active low
// Notes: bound to the top module
`timescale 1ns/1ps
`include "sdh_regs.svh"
module sdh_search_checker
  import sdh_pkg::*;
(
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // inputs watched
  input wire logic I_CDB_VALID,
  input wire logic [79:0] I_CDB,
  input wire logic I_DISC_ENABLE,
  // outputs watched
  input wire logic O_DISK_READY,
  input wire logic O_BLK_RD,
  input wire logic [31:0] O_BLK_LBA,
  input wire logic O_BUSY,
  input wire logic O_DISCONNECT,
  input wire logic O_STATUS_VALID,
  input wire logic [7:0] O_STATUS,
  input wire logic O_FETCH_NEXT,
  input wire logic O_LINK_IRQ,
  input sdh_sense_type O_SENSE
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  property p_opcode;
    I_CDB_VALID && !O_BUSY && I_CDB[79:72] != `SDH_OPCODE
      |-> ##2 (O_STATUS_VALID && O_STATUS == `SDH_ST_CHECK);
  endproperty
  a_opcode: assert property (p_opcode) else $error("other opcode not refused");
  property p_pulse;
    O_STATUS_VALID |=> !O_STATUS_VALID;
  endproperty
  a_pulse: assert property (p_pulse) else $error("status pulse too long");
  property p_fetch;
    O_FETCH_NEXT |-> O_STATUS_VALID && O_STATUS == `SDH_ST_INTER_MET;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch without linked status");
  property p_irq;
    O_LINK_IRQ |-> O_FETCH_NEXT;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt outside linked success");
  property p_met;
    O_STATUS_VALID && O_STATUS == `SDH_ST_COND_MET |-> O_SENSE.valid_address_indicator
      && (O_SENSE.key == `SDH_KEY_EQUAL || O_SENSE.key == `SDH_KEY_NO_SENSE);
  endproperty
  a_met: assert property (p_met) else $error("match sense wrong");
  property p_miss;
    O_STATUS_VALID && O_STATUS == `SDH_ST_GOOD
      |-> !O_SENSE.valid_address_indicator && O_SENSE.key == `SDH_KEY_NO_SENSE;
  endproperty
  a_miss: assert property (p_miss) else $error("miss sense wrong");
  property p_check;
    O_STATUS_VALID && O_STATUS == `SDH_ST_CHECK |-> O_SENSE.key == `SDH_KEY_ILLEGAL;
  endproperty
  a_check: assert property (p_check) else $error("check without illegal key");
  property p_disc;
    (O_DISK_READY || O_BLK_RD) |-> O_DISCONNECT == I_DISC_ENABLE;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect wrong");
  property p_rd;
    O_BLK_RD |=> O_DISK_READY && $stable(O_BLK_LBA);
  endproperty
  a_rd: assert property (p_rd) else $error("block read not followed by data");
  c_met: cover property (O_STATUS_VALID && O_STATUS == `SDH_ST_COND_MET);
  c_inter: cover property (O_STATUS_VALID && O_STATUS == `SDH_ST_INTER_MET);
  c_check: cover property (O_STATUS_VALID && O_STATUS == `SDH_ST_CHECK);
endmodule

bind sdh_search_top sdh_search_checker sdh_search_checker_i (
  .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_CDB_VALID(I_CDB_VALID), .I_CDB(I_CDB),
  .I_DISC_ENABLE(I_DISC_ENABLE), .O_DISK_READY(O_DISK_READY), .O_BLK_RD(O_BLK_RD),
  .O_BLK_LBA(O_BLK_LBA), .O_BUSY(O_BUSY), .O_DISCONNECT(O_DISCONNECT),
  .O_STATUS_VALID(O_STATUS_VALID), .O_STATUS(O_STATUS), .O_FETCH_NEXT(O_FETCH_NEXT),
  .O_LINK_IRQ(O_LINK_IRQ), .O_SENSE(O_SENSE)
);

// >>> tb/sdh_disk_model.sv
// Purpose: disk side serving blocks 0 to 7
// Assumes: 16-byte blocks, memory loaded by the bench
// Notes: idle byte line toggles, optional stall
`timescale 1ns/1ps
module sdh_disk_model
#(
  parameter int BLOCK_BYTES = 16
)
(
  // from the design
  input wire logic i_clk,
  input wire logic i_blk_rd,
  input wire logic [31:0] i_blk_lba,
  input wire logic i_ready,
  input wire logic i_slow,
  // to the design
  output logic o_valid = 1'b0,
  output logic [7:0] o_byte = 8'h5a
);
  logic [7:0] mem [0:127];
  logic [2:0] blk = 3'h0;
  logic active = 1'b0;
  logic tick = 1'b0;
  int cnt = 0;
  always @(posedge i_clk)
  begin
    if (i_blk_rd)
    begin
      blk <= i_blk_lba[2:0];
      cnt <= 0;
      active <= 1'b1;
    end
    else if (o_valid && i_ready)
      cnt <= cnt + 1;
  end
  always @(negedge i_clk)
  begin
    tick <= ~tick;
    if (active && cnt < BLOCK_BYTES && !(i_slow && tick))
    begin
      o_valid <= 1'b1;
      o_byte <= mem[blk * BLOCK_BYTES + cnt];
    end
    else
    begin
      o_valid <= 1'b0;
      o_byte <= ~o_byte;
    end
  end
endmodule

// >>> tb/sdh_search_top_tb.sv
// Purpose: self-checking bench for the data search command
// Assumes: 16-byte blocks, disk model holds blocks 0 to 7
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`include "sdh_regs.svh"
module sdh_search_top_tb;
  import sdh_pkg::*;
  logic I_SYS_CLK;
  logic I_RESETN;
  logic I_CDB_VALID;
  logic [79:0] I_CDB;
  logic I_PARAM_VALID;
  sdh_param_type I_PARAM;
  sdh_field_type [1:0] I_FIELDS;
  logic I_DISC_ENABLE;
  logic I_DISK_VALID;
  logic [7:0] I_DISK_BYTE;
  logic O_DISK_READY;
  logic O_BLK_RD;
  logic [31:0] O_BLK_LBA;
  logic O_BUSY;
  logic O_DISCONNECT;
  logic O_STATUS_VALID;
  logic [7:0] O_STATUS;
  logic O_FETCH_NEXT;
  logic O_LINK_IRQ;
  logic O_NEGATED_MATCH;
  sdh_sense_type O_SENSE;
  sdh_sense_type sense;
  logic [7:0] st;
  logic [31:0] lba0;
  logic fetch;
  logic irq;
  logic slow;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  sdh_search_top #(.BLOCK_BYTES(16)) sdh_search_top_i (
    .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_CDB_VALID(I_CDB_VALID), .I_CDB(I_CDB),
    .I_PARAM_VALID(I_PARAM_VALID), .I_PARAM(I_PARAM), .I_FIELDS(I_FIELDS),
    .I_DISC_ENABLE(I_DISC_ENABLE), .I_DISK_VALID(I_DISK_VALID), .I_DISK_BYTE(I_DISK_BYTE),
    .O_DISK_READY(O_DISK_READY), .O_BLK_RD(O_BLK_RD), .O_BLK_LBA(O_BLK_LBA), .O_BUSY(O_BUSY),
    .O_DISCONNECT(O_DISCONNECT), .O_STATUS_VALID(O_STATUS_VALID), .O_STATUS(O_STATUS),
    .O_FETCH_NEXT(O_FETCH_NEXT), .O_LINK_IRQ(O_LINK_IRQ), .O_NEGATED_MATCH(O_NEGATED_MATCH),
    .O_SENSE(O_SENSE)
  );
  sdh_disk_model #(.BLOCK_BYTES(16)) sdh_disk_model_i (
    .i_clk(I_SYS_CLK), .i_blk_rd(O_BLK_RD), .i_blk_lba(O_BLK_LBA), .i_ready(O_DISK_READY),
    .i_slow(slow), .o_valid(I_DISK_VALID), .o_byte(I_DISK_BYTE)
  );
  task automatic finish_test();
    $display("tests run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [79:0] mk(input int b1, input int lba, input int cnt, input int b9);
    return {`SDH_OPCODE, b1[7:0], lba, 8'h00, cnt[15:0], b9[7:0]};
  endfunction
  task automatic fld(input int disp, input int size, input int pat);
    I_FIELDS[0] = {disp, size[15:0], pat};
    I_FIELDS[1] = '0;
  endtask
  task automatic run(input logic [79:0] cdb, input int rsz, input int foff, input int rcnt);
    int n;
    I_CDB = cdb;
    I_CDB_VALID = 1'b1;
    @(negedge I_SYS_CLK);
    I_CDB_VALID = 1'b0;
    I_PARAM = {rsz, foff, rcnt};
    I_PARAM_VALID = 1'b1;
    @(negedge I_SYS_CLK);
    I_PARAM_VALID = 1'b0;
    lba0 = '1;
    n = 0;
    while (O_STATUS_VALID !== 1'b1 && n < 400)
    begin
      if (O_BLK_RD === 1'b1 && lba0 === '1)
        lba0 = O_BLK_LBA;
      @(negedge I_SYS_CLK);
      n++;
    end
    check(n < 400, 1);
    st = O_STATUS;
    sense = O_SENSE;
    fetch = O_FETCH_NEXT;
    irq = O_LINK_IRQ;
    @(negedge I_SYS_CLK);
  endtask
  task automatic res(input int est, input int ekey, input int evai, input int einfo,
                     input int eoff);
    check(st, est);
    check(sense.key, ekey);
    check(sense.valid_address_indicator, evai);
    if (evai != 0)
    begin
      check(sense.info, einfo);
      check(sense.rec_off, eoff);
    end
  endtask
  initial
  begin
    I_SYS_CLK = 1'b0;
    forever #12.5 I_SYS_CLK = ~I_SYS_CLK;
  end
  always @(posedge I_SYS_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    I_RESETN = 1'b0;
    I_CDB_VALID = 1'b0;
    I_CDB = '0;
    I_PARAM_VALID = 1'b0;
    I_PARAM = '0;
    I_FIELDS = '0;
    I_DISC_ENABLE = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 128; i++)
      sdh_disk_model_i.mem[i] = 8'h00;
    sdh_disk_model_i.mem[56] = 8'h12;
    sdh_disk_model_i.mem[57] = 8'h34;
    sdh_disk_model_i.mem[64] = 8'h20;
    sdh_disk_model_i.mem[95] = 8'hff;
    sdh_disk_model_i.mem[96] = 8'hff;
    sdh_disk_model_i.mem[112] = 8'h03;
    sdh_disk_model_i.mem[115] = 8'h04;
    sdh_disk_model_i.mem[116] = 8'h50;
    repeat (8) @(negedge I_SYS_CLK);
    I_RESETN = 1'b1;
    repeat (3) @(negedge I_SYS_CLK);
    fld(0, 2, 32'h1234_0000);
    run(mk(0, 2, 2, 0) ^ {8'h01, 72'h0}, 4, 0, 100);
    check(st, `SDH_ST_CHECK);
    run(mk(8'h10, 2, 2, 0), 4, 0, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_EQUAL, 1, 3, 8);
    check(O_NEGATED_MATCH, 1);
    check(lba0, 2);
    fld(0, 2, 32'h1233_0000);
    run(mk(0, 2, 2, 0), 4, 0, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_NO_SENSE, 1, 3, 8);
    check(O_NEGATED_MATCH, 0);
    fld(0, 2, 32'h1235_0000);
    run(mk(0, 2, 2, 0), 4, 0, 100);
    res(`SDH_ST_GOOD, `SDH_KEY_NO_SENSE, 0, 0, 0);
    fld(0, 2, 32'h1234_0000);
    run(mk(0, 2, 1, 0), 4, 0, 100);
    res(`SDH_ST_GOOD, `SDH_KEY_NO_SENSE, 0, 0, 0);
    run(mk(0, 3, 1, 0), 4, 0, 2);
    res(`SDH_ST_GOOD, `SDH_KEY_NO_SENSE, 0, 0, 0);
    run(mk(0, 2, 0, 0), 4, 0, 100);
    check(lba0, 32'hffff_ffff);
    run(mk(0, 3, 2, 0), 4, 12, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_NO_SENSE, 1, 4, 0);
    fld(0, 2, 32'hff00_0000);
    run(mk(0, 5, 2, 0), 5, 0, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_EQUAL, 1, 6, 0);
    run(mk(8'h02, 5, 2, 0), 5, 0, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_NO_SENSE, 1, 5, 15);
    fld(1, 1, 32'h5000_0000);
    run(mk(8'h04, 7, 1, 0), 4, 0, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_EQUAL, 1, 7, 3);
    fld(0, 1, 32'h1200_0000);
    I_FIELDS[1] = {32'h1, 16'h1, 32'h3500_0000};
    run(mk(0, 3, 1, 0), 4, 0, 100);
    res(`SDH_ST_GOOD, `SDH_KEY_NO_SENSE, 0, 0, 0);
    I_FIELDS[1] = {32'h1, 16'h1, 32'h3400_0000};
    run(mk(0, 3, 1, 0), 4, 0, 100);
    res(`SDH_ST_COND_MET, `SDH_KEY_EQUAL, 1, 3, 8);
    I_DISC_ENABLE = 1'b1;
    slow = 1'b1;
    fld(0, 2, 32'h1234_0000);
    run(mk(0, 2, 2, 3), 4, 0, 100);
    check(st, `SDH_ST_INTER_MET);
    check(fetch, 1);
    check(irq, 1);
    run(mk(8'h01, -1, 1, 0), 4, 0, 100);
    check(lba0, 2);
    run(mk(8'h01, -1, 1, 0), 4, 0, 100);
    check(st, `SDH_ST_CHECK);
    check(sense.key, `SDH_KEY_ILLEGAL);
    fld(0, 2, 32'hffff_0000);
    run(mk(0, 2, 1, 1), 4, 0, 100);
    check(st, `SDH_ST_GOOD);
    check(fetch, 0);
    finish_test();
  end
endmodule
